// ---- design/cam_monitor.sv ----
// current average pulse monitor: timing machine, hour counter, apb registers
// Summary of operation
// - repeat 20 s pulse cycle at constant speed
// - 1 s start pulse, average 0.1-1 s
// - ignore current for mask time after accel from idle
// - reference current is the 100 percent point
// - low pulse = average / reference x 5 s
// - low pulse clamped 0.5 to 9 s
// - high pulse = hours x100 / 40000 x 5 s
// - high pulse clamped 2 to 9 s
// - no mask or sampling while accelerating
// - speed lost in start: 3.5 high, 16.5 low
// - a started cycle always completes
// - zero current at cycle end stops output
// - accelerating at cycle end: 20 s low
// - restart active: 20 s low without data
// - routed to open collector, never relay
// - hour counter in 100 h, saturates 9998
`timescale 1ns/1ns
`default_nettype none
`include "cam_params.svh"
module cam_monitor #(
	parameter int TICK_CYCLES = `CAM_TICK_CYC
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire cam_pkg::cam_apb_req_t apb_req,
	output var cam_pkg::cam_apb_rsp_t apb_rsp,
	input wire cam_pkg::cam_drive_t drive,
	output var cam_pkg::cam_pins_t pins
);
	import cam_pkg::*;

	localparam logic [7:0] START_T = 8'(`CAM_TK(`CAM_START_MS));
	localparam logic [7:0] CYCLE_T = 8'(`CAM_TK(`CAM_CYCLE_MS));
	localparam logic [7:0] INVH_T = 8'(`CAM_TK(`CAM_INV_HI_MS));
	localparam logic [7:0] LOW_MIN = 8'(`CAM_TK(`CAM_LOW_MIN_MS));
	localparam logic [7:0] LOW_MAX = 8'(`CAM_TK(`CAM_LOW_MAX_MS));
	localparam logic [7:0] MNT_MIN = 8'(`CAM_TK(`CAM_MNT_MIN_MS));
	localparam logic [7:0] MNT_MAX = 8'(`CAM_TK(`CAM_MNT_MAX_MS));
	localparam logic [7:0] MASK_MAX = 8'(`CAM_TK(`CAM_MASK_MAX_MS));
	localparam logic [3:0] AVG_MIN = 4'(`CAM_TK(`CAM_AVG_MIN_MS));
	localparam logic [3:0] AVG_MAX = 4'(`CAM_TK(`CAM_AVG_MAX_MS));
	localparam int FULL_T = `CAM_TK(`CAM_FULL_MS);

	logic [22:0] div_q;
	logic tick;
	logic const_prev_q;
	logic const_rise;
	cam_state_t st_q;
	cam_state_t st_d;
	cam_state_t st_next_cycle;
	logic cyc_clr;
	logic cyc_end;
	logic in_cycle;
	logic [7:0] cyc_q;
	logic [7:0] mcnt_q;
	logic mask_done;
	logic [16:0] sum_q;
	logic [16:0] sum_fin;
	logic samp;
	logic [7:0] low_q;
	logic [7:0] mnt_q;
	logic [7:0] low_t;
	logic [7:0] mnt_t;
	logic [22:0] num;
	logic [16:0] den;
	logic [22:0] quo;
	int hrs_h;
	logic sig;
	logic rst_on;
	logic [3:0] avg_q;
	logic [7:0] mask_q;
	logic [12:0] ref_q;
	logic [7:0] route_a_q;
	logic [7:0] route_b_q;
	logic [7:0] relay_q;
	logic [13:0] coast_q;
	logic [6:0] hsub_q;
	logic [13:0] hrs_q;
	logic setup;
	logic wr;
	logic [31:0] wd;
	logic [31:0] rdata_d;
	logic err_d;
	logic [3:0] avg_w;
	logic [7:0] mask_w;
	logic [12:0] ref_w;
	logic [7:0] relay_w;

	// 0.1 s timebase
	assign tick = (div_q == 23'(TICK_CYCLES - 1));
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			div_q <= 23'h0;
		end else if (tick) begin
			div_q <= 23'h0;
		end else begin
			div_q <= div_q + 23'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			const_prev_q <= 1'b0;
		end else begin
			const_prev_q <= drive.const_speed;
		end
	end
	assign const_rise = drive.const_speed & ~const_prev_q;
	assign rst_on = (coast_q != `CAM_NO_RESTART);
	assign in_cycle = (st_q != cam_idle) && (st_q != cam_mask);
	assign cyc_end = tick && (cyc_q == CYCLE_T - 8'h1);
	assign mask_done = (mcnt_q >= mask_q);

	// decision taken when a cycle completes
	always_comb begin
		if (drive.current == 13'h0) begin
			st_next_cycle = cam_idle;
		end else if (!drive.const_speed) begin
			st_next_cycle = cam_nodata;
		end else if (rst_on && drive.restart_active) begin
			st_next_cycle = cam_nodata;
		end else begin
			st_next_cycle = cam_start;
		end
	end

	always_comb begin
		st_d = st_q;
		cyc_clr = 1'b0;
		case (st_q)
			cam_idle: begin
				if (const_rise) begin
					st_d = cam_mask;
				end
			end
			cam_mask: begin
				if (!drive.const_speed) begin
					st_d = cam_idle;
				end else if (mask_done) begin
					st_d = (rst_on && drive.restart_active) ? cam_nodata : cam_start;
					cyc_clr = 1'b1;
				end
			end
			cam_start: begin
				if (!drive.const_speed) begin
					st_d = cam_invh;
				end else if (tick && cyc_q == START_T - 8'h1) begin
					st_d = cam_cur;
				end
			end
			cam_cur: begin
				if (tick && cyc_q == START_T + low_q - 8'h1) begin
					st_d = cam_mnt;
				end
			end
			cam_mnt: begin
				if (tick && cyc_q == START_T + low_q + mnt_q - 8'h1) begin
					st_d = cam_end;
				end
			end
			cam_invh: begin
				if (tick && cyc_q == INVH_T - 8'h1) begin
					st_d = cam_invl;
				end
			end
			cam_end, cam_invl, cam_nodata: begin
				st_d = st_q;
			end
			default: begin
				st_d = cam_idle;
			end
		endcase
		if (in_cycle && cyc_end) begin
			st_d = st_next_cycle;
			cyc_clr = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_q <= cam_idle;
		end else begin
			st_q <= st_d;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			cyc_q <= 8'h0;
		end else if (cyc_clr || !in_cycle) begin
			cyc_q <= 8'h0;
		end else if (tick) begin
			cyc_q <= cyc_q + 8'h1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			mcnt_q <= 8'h0;
		end else if (st_q != cam_mask) begin
			mcnt_q <= 8'h0;
		end else if (tick && !mask_done) begin
			mcnt_q <= mcnt_q + 8'h1;
		end
	end

	// average over the last avg_q ticks of the start pulse
	assign samp = (st_q == cam_start) && tick && drive.const_speed && (cyc_q >= START_T - 8'(avg_q));
	assign sum_fin = sum_q + (samp ? 17'(drive.current) : 17'h0);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sum_q <= 17'h0;
		end else if (st_q != cam_start) begin
			sum_q <= 17'h0;
		end else begin
			sum_q <= sum_fin;
		end
	end

	always_comb begin
		num = 23'(sum_fin) * 23'(FULL_T);
		den = 17'(avg_q) * 17'(ref_q);
		quo = (den == 17'h0) ? 23'h7fffff : num / 23'(den);
		if (quo < 23'(LOW_MIN)) begin
			low_t = LOW_MIN;
		end else if (quo > 23'(LOW_MAX)) begin
			low_t = LOW_MAX;
		end else begin
			low_t = quo[7:0];
		end
	end

	always_comb begin
		hrs_h = int'(hrs_q) * `CAM_UNIT_H;
		if (hrs_h < `CAM_LOW_H) begin
			mnt_t = MNT_MIN;
		end else if (hrs_h > `CAM_HIGH_H) begin
			mnt_t = MNT_MAX;
		end else begin
			mnt_t = 8'(hrs_h * FULL_T / `CAM_FULL_H);
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			low_q <= LOW_MIN;
			mnt_q <= MNT_MIN;
		end else if (st_q == cam_start && st_d == cam_cur) begin
			low_q <= low_t;
			mnt_q <= mnt_t;
		end
	end

	// output pins, polarity by route code
	assign sig = (st_q == cam_start) || (st_q == cam_mnt) || (st_q == cam_invh);
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pins <= '0;
		end else begin
			pins.route_a <= (route_a_q == `CAM_ROUTE_POS) ? sig : (route_a_q == `CAM_ROUTE_NEG) & ~sig;
			pins.route_b <= (route_b_q == `CAM_ROUTE_POS) ? sig : (route_b_q == `CAM_ROUTE_NEG) & ~sig;
		end
	end

	// powered hour counter in 100 h units
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hsub_q <= 7'h0;
			hrs_q <= 14'h0;
		end else if (wr && apb_req.paddr == `CAM_OFS_HOURS && hrs_q != 14'h0 && wd[13:0] == 14'h0) begin
			hsub_q <= {6'h0, drive.hour_tick};
			hrs_q <= 14'h0;
		end else if (drive.hour_tick) begin
			if (hsub_q == 7'(`CAM_UNIT_H - 1)) begin
				hsub_q <= 7'h0;
				if (hrs_q < `CAM_HRS_SAT) begin
					hrs_q <= hrs_q + 14'h1;
				end
			end else begin
				hsub_q <= hsub_q + 7'h1;
			end
		end
	end

	// apb slave, no wait states
	assign setup = apb_req.psel & ~apb_req.penable;
	assign wr = apb_req.psel & apb_req.penable & apb_rsp.pready & apb_req.pwrite & ~apb_rsp.pslverr;
	assign wd = apb_req.pwdata;
	assign avg_w = (wd[3:0] < AVG_MIN) ? AVG_MIN : (wd[3:0] > AVG_MAX) ? AVG_MAX : wd[3:0];
	assign mask_w = (wd[`CAM_MASK_LSB +: 8] > MASK_MAX) ? MASK_MAX : wd[`CAM_MASK_LSB +: 8];
	assign ref_w = (wd[12:0] > `CAM_REF_MAX) ? `CAM_REF_MAX : wd[12:0];
	assign relay_w = wd[`CAM_RELAY_LSB +: 8];

	always_comb begin
		rdata_d = 32'h0;
		err_d = 1'b0;
		if (apb_req.paddr == `CAM_OFS_TIME) begin
			rdata_d = {16'h0, mask_q, 4'h0, avg_q};
		end else if (apb_req.paddr == `CAM_OFS_REF) begin
			rdata_d = {19'h0, ref_q};
		end else if (apb_req.paddr == `CAM_OFS_ROUTE) begin
			rdata_d = {8'h0, relay_q, route_b_q, route_a_q};
			err_d = apb_req.pwrite && (relay_w == `CAM_ROUTE_POS || relay_w == `CAM_ROUTE_NEG);
		end else if (apb_req.paddr == `CAM_OFS_COAST) begin
			rdata_d = {18'h0, coast_q};
		end else if (apb_req.paddr == `CAM_OFS_STAT) begin
			rdata_d = {8'h0, cyc_q, 7'h0, st_q};
			err_d = apb_req.pwrite;
		end else if (apb_req.paddr == `CAM_OFS_HOURS) begin
			rdata_d = {18'h0, hrs_q};
		end else if (apb_req.paddr == `CAM_OFS_WIDTH) begin
			rdata_d = {16'h0, mnt_q, low_q};
			err_d = apb_req.pwrite;
		end else begin
			err_d = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			apb_rsp <= '0;
		end else if (setup) begin
			apb_rsp.prdata <= rdata_d;
			apb_rsp.pready <= 1'b1;
			apb_rsp.pslverr <= err_d;
		end else begin
			apb_rsp <= '0;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			avg_q <= `CAM_AVG_RST;
			mask_q <= `CAM_MASK_RST;
		end else if (wr && apb_req.paddr == `CAM_OFS_TIME) begin
			avg_q <= avg_w;
			mask_q <= mask_w;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ref_q <= `CAM_REF_RST;
		end else if (wr && apb_req.paddr == `CAM_OFS_REF) begin
			ref_q <= ref_w;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			route_a_q <= `CAM_ROUTE_RST;
			route_b_q <= `CAM_ROUTE_RST;
			relay_q <= `CAM_ROUTE_RST;
		end else if (wr && apb_req.paddr == `CAM_OFS_ROUTE) begin
			route_a_q <= wd[7:0];
			route_b_q <= wd[`CAM_ROUTE_B_LSB +: 8];
			relay_q <= relay_w;
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			coast_q <= `CAM_COAST_RST;
		end else if (wr && apb_req.paddr == `CAM_OFS_COAST) begin
			coast_q <= wd[13:0];
		end
	end
endmodule
`default_nettype wire

// ---- design/cam_params.svh ----
// constants of the current average pulse monitor
`ifndef CAM_PARAMS_SVH
`define CAM_PARAMS_SVH
`define CAM_CLK_NS 20
`define CAM_TICK_MS 100
`define CAM_TICK_CYC (`CAM_TICK_MS * 1000000 / `CAM_CLK_NS)
`define CAM_TK(ms) ((ms) / `CAM_TICK_MS)
`define CAM_CYCLE_MS 20000
`define CAM_START_MS 1000
`define CAM_FULL_MS 5000
`define CAM_LOW_MIN_MS 500
`define CAM_LOW_MAX_MS 9000
`define CAM_MNT_MIN_MS 2000
`define CAM_MNT_MAX_MS 9000
`define CAM_INV_HI_MS 3500
`define CAM_AVG_MIN_MS 100
`define CAM_AVG_MAX_MS 1000
`define CAM_MASK_MAX_MS 20000
`define CAM_FULL_H 40000
`define CAM_LOW_H 16000
`define CAM_HIGH_H 72000
`define CAM_UNIT_H 100
`define CAM_HRS_SAT 14'd9998
`define CAM_NO_RESTART 14'd9999
`define CAM_ROUTE_POS 8'd93
`define CAM_ROUTE_NEG 8'd193
`define CAM_REF_MAX 13'd5000
`define CAM_AVG_RST 4'd10
`define CAM_MASK_RST 8'd0
`define CAM_REF_RST 13'd50
`define CAM_ROUTE_RST 8'd0
`define CAM_COAST_RST 14'd9999
`define CAM_OFS_TIME 8'h00
`define CAM_OFS_REF 8'h04
`define CAM_OFS_ROUTE 8'h08
`define CAM_OFS_COAST 8'h0c
`define CAM_OFS_STAT 8'h10
`define CAM_OFS_HOURS 8'h14
`define CAM_OFS_WIDTH 8'h18
`define CAM_MASK_LSB 8
`define CAM_ROUTE_B_LSB 8
`define CAM_RELAY_LSB 16
`endif

// ---- design/cam_pkg.sv ----
// types of the current average pulse monitor
package cam_pkg;
	typedef enum logic [8:0] {
		cam_idle = 9'h001,
		cam_mask = 9'h002,
		cam_start = 9'h004,
		cam_cur = 9'h008,
		cam_mnt = 9'h010,
		cam_end = 9'h020,
		cam_invh = 9'h040,
		cam_invl = 9'h080,
		cam_nodata = 9'h100
	} cam_state_t;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} cam_apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} cam_apb_rsp_t;
	typedef struct packed {
		logic const_speed;
		logic restart_active;
		logic hour_tick;
		logic [12:0] current;
	} cam_drive_t;
	typedef struct packed {
		logic route_a;
		logic route_b;
	} cam_pins_t;
endpackage

// ---- verif/cam_monitor_properties.sv ----
// port assertions of the current average pulse monitor
`timescale 1ns/1ns
`default_nettype none
module cam_monitor_properties #(
	parameter int TICK_CYCLES = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire cam_pkg::cam_apb_req_t apb_req,
	input wire cam_pkg::cam_apb_rsp_t apb_rsp,
	input wire cam_pkg::cam_drive_t drive,
	input wire cam_pkg::cam_pins_t pins
);
	import cam_pkg::*;
	logic [15:0] hi_q;
	logic su;
	assign su = apb_req.psel && !apb_req.penable;
	// length of the running high phase of the positive route
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			hi_q <= 16'h0;
		end else begin
			hi_q <= pins.route_a ? hi_q + 16'h1 : 16'h0;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	apb_ready_a: assert property (su |=> apb_rsp.pready)
		else $error("no ready after setup");
	ready_once_a: assert property (apb_rsp.pready |=> !apb_rsp.pready)
		else $error("ready held");
	err_ready_a: assert property (apb_rsp.pslverr |-> apb_rsp.pready)
		else $error("error without ready");
	unmapped_rd_a: assert property (su && apb_req.paddr > 8'h18
		|=> apb_rsp.pslverr && apb_rsp.prdata == 32'h0)
		else $error("unmapped access answered");
	ro_write_a: assert property (su && apb_req.pwrite && apb_req.paddr == 8'h10 |=> apb_rsp.pslverr)
		else $error("status write accepted");
	relay_code_a: assert property (su && apb_req.pwrite && apb_req.paddr == 8'h08
		&& apb_req.pwdata[23:16] inside {8'd93, 8'd193} |=> apb_rsp.pslverr)
		else $error("relay route accepted");
	width_rng_a: assert property (su && !apb_req.pwrite && apb_req.paddr == 8'h18
		|=> (apb_rsp.prdata[7:0] inside {[5:90]} || apb_rsp.prdata[7:0] == 8'h0)
		&& (apb_rsp.prdata[15:8] inside {[20:90]} || apb_rsp.prdata[15:8] == 8'h0))
		else $error("width out of range");
	high_len_a: assert property ($fell(pins.route_a)
		|-> hi_q > 9 * TICK_CYCLES && hi_q <= 90 * TICK_CYCLES)
		else $error("high phase length wrong");
	rst_pins_a: assert property ($rose(reset_n) |-> pins == 2'b00)
		else $error("pins active after reset");
endmodule
`default_nettype wire

// ---- verif/cam_plc_model.sv ----
// controller input that measures the widths of the monitor pulses
`timescale 1ns/1ns
`default_nettype none
module cam_plc_model #(
	parameter int T = 4
) (
	input wire logic clk,
	input wire logic sig,
	output logic ev,
	output logic [7:0] lo_w,
	output logic [7:0] hi_w
);
	int run = 0;
	int ph = 0;
	int lo = 0;
	logic last = 1'b0;
	initial begin
		ev = 1'b0;
		lo_w = 8'h0;
		hi_w = 8'h0;
	end
	// a start pulse arms the measurement of one low and one high phase
	always @(posedge clk) begin
		ev <= 1'b0;
		if (sig === last) begin
			run = run + 1;
		end else begin
			if (last && run > 9 * T && run <= 10 * T) begin
				ph = 1;
			end else if (last && run > 34 * T && run <= 35 * T) begin
				lo_w <= 8'hff;
				hi_w <= 8'd35;
				ev <= 1'b1;
				ph = 0;
			end else if (!last && ph == 1) begin
				lo = run;
				ph = 2;
			end else if (last && ph == 2) begin
				lo_w <= 8'(lo / T);
				hi_w <= 8'(run / T);
				ev <= 1'b1;
				ph = 0;
			end else begin
				ph = 0;
			end
			run = 1;
			last = sig;
		end
	end
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
// self-checking bench of the current average pulse monitor
`timescale 1ns/1ns
`default_nettype none
module tb;
	import cam_pkg::*;
	localparam int T = 4;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	cam_apb_req_t rq = '0;
	cam_apb_rsp_t rs;
	cam_drive_t dv = '0;
	cam_pins_t pins;
	logic ev;
	logic [7:0] lo_w;
	logic [7:0] hi_w;
	int errors = 0;
	int cmp_count = 0;
	int evn = 0;
	int cur;
	int l;
	logic [64:0] e;
	logic [15:0] p;
	logic [64:0] aq[$];
	logic [15:0] pq[$];
	logic [31:0] seed = 32'd78;
	logic [7:0] ra[5] = '{8'h0, 8'h4, 8'h8, 8'hc, 8'h14};
	logic [31:0] rv[5] = '{32'ha, 32'h32, 32'h0, 32'h270f, 32'h0};
	int ct[4] = '{9, 10, 180, 185};
	always #10 clk = ~clk;
	cam_monitor #(.TICK_CYCLES(T)) i_cam_monitor (.clk(clk), .reset_n(reset_n), .apb_req(rq),
		.apb_rsp(rs), .drive(dv), .pins(pins));
	cam_plc_model #(.T(T)) i_cam_plc_model (.clk(clk), .sig(pins.route_a), .ev(ev),
		.lo_w(lo_w), .hi_w(hi_w));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic finish_test();
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [31:0] x, logic [31:0] s);
		cmp_count++;
		if (s !== x) begin
			errors++;
			$display("Error %s expected %h seen %h", n, x, s);
		end
	endtask
	task automatic apb(logic w, logic [7:0] a, logic [31:0] d, logic [31:0] x, logic [31:0] m,
		logic er);
		int n;
		n = 0;
		aq.push_back({er, m, x});
		rq <= '{1'b1, 1'b0, w, a, d};
		@(posedge clk);
		rq.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (rs.pready !== 1'b1 && n < 50);
		rq <= '0;
		@(posedge clk);
		if (n >= 50) begin
			errors++;
			finish_test();
		end
	endtask
	task automatic wait_ev(int k);
		int n;
		n = 0;
		while (evn < k && n < 3000) begin
			@(posedge clk);
			n++;
		end
		if (evn < k) begin
			errors++;
			finish_test();
		end
	endtask
	// results are taken off the queues in the cycle they appear
	always @(posedge clk) begin
		if (rs.pready === 1'b1) begin
			e = aq.pop_front();
			chk("prdata", e[31:0] & e[63:32], rs.prdata & e[63:32]);
			chk("pslverr", {31'h0, e[64]}, {31'h0, rs.pslverr});
		end
		if (ev === 1'b1) begin
			p = pq.pop_front();
			evn++;
			chk("low width", {24'h0, p[15:8]}, {24'h0, lo_w});
			chk("high width", {24'h0, p[7:0]}, {24'h0, hi_w});
			chk("route_b", {31'h0, ~pins.route_a}, {31'h0, pins.route_b});
		end
	end
	initial begin
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		for (int i = 0; i < 5; i++) apb(1'b0, ra[i], 32'h0, rv[i], '1, 1'b0);
		apb(1'b0, 8'h1c, 32'h0, 32'h0, '1, 1'b1);
		apb(1'b1, 8'h10, 32'h1, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h08, 32'h5d0000, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 8'h08, 32'h0, 32'h0, '1, 1'b0);
		apb(1'b1, 8'h04, 32'h64, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 8'h08, 32'hc15d, 32'h0, 32'h0, 1'b0);
		dv.current <= 13'd150;
		dv.const_speed <= 1'b1;
		pq.push_back({8'd75, 8'd20});
		wait_ev(1);
		apb(1'b0, 8'h18, 32'h0, 32'h144b, 32'hffff, 1'b0);
		for (int i = 0; i < 6; i++) begin
			cur = i < 4 ? ct[i] : int'(rnd() % 259) + 1;
			l = cur * 50 / 100;
			l = l < 5 ? 5 : l > 90 ? 90 : l;
			dv.current <= cur[12:0];
			apb(1'b1, 8'h00, i[0] ? 32'h1 : 32'ha, 32'h0, 32'h0, 1'b0);
			pq.push_back({l[7:0], 8'd20});
			wait_ev(i + 2);
		end
		// speed lost between cycles: no data while hours accumulate
		dv.const_speed <= 1'b0;
		dv.current <= 13'd150;
		repeat (17000) begin
			dv.hour_tick <= 1'b1;
			@(posedge clk);
			dv.hour_tick <= 1'b0;
			@(posedge clk);
		end
		apb(1'b0, 8'h10, 32'h0, 32'h100, 32'h1ff, 1'b0);
		apb(1'b0, 8'h14, 32'h0, 32'haa, '1, 1'b0);
		pq.push_back({8'd75, 8'd21});
		dv.const_speed <= 1'b1;
		// speed lost once the start pulse is over: the cycle still carries its data
		l = 0;
		while (pins.route_a !== 1'b1 && l < 2000) begin
			@(posedge clk);
			l++;
		end
		while (pins.route_a === 1'b1 && l < 2000) begin
			@(posedge clk);
			l++;
		end
		if (l >= 2000) begin
			errors++;
			finish_test();
		end
		dv.const_speed <= 1'b0;
		wait_ev(8);
		dv.const_speed <= 1'b1;
		apb(1'b1, 8'h14, 32'h5, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 8'h14, 32'h0, 32'haa, '1, 1'b0);
		apb(1'b1, 8'h14, 32'h0, 32'h0, 32'h0, 1'b0);
		apb(1'b0, 8'h14, 32'h0, 32'h0, '1, 1'b0);
		pq.push_back({8'hff, 8'd35});
		repeat (380) @(posedge clk);
		dv.const_speed <= 1'b0;
		wait_ev(9);
		apb(1'b0, 8'h10, 32'h0, 32'h80, 32'h1ff, 1'b0);
		repeat (700) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0, 32'h100, 32'h1ff, 1'b0);
		dv.current <= 13'd0;
		repeat (900) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0, 32'h1, 32'h1ff, 1'b0);
		pq.push_back({8'd5, 8'd20});
		dv.const_speed <= 1'b1;
		wait_ev(10);
		repeat (700) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0, 32'h1, 32'h1ff, 1'b0);
		apb(1'b1, 8'h0c, 32'h3, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 8'h00, 32'h50a, 32'h0, 32'h0, 1'b0);
		dv.current <= 13'd150;
		dv.restart_active <= 1'b1;
		dv.const_speed <= 1'b0;
		@(posedge clk);
		dv.const_speed <= 1'b1;
		@(posedge clk);
		apb(1'b0, 8'h10, 32'h0, 32'h2, 32'h1ff, 1'b0);
		repeat (30) @(posedge clk);
		apb(1'b0, 8'h10, 32'h0, 32'h100, 32'h1ff, 1'b0);
		finish_test();
	end
endmodule
bind cam_monitor cam_monitor_properties #(.TICK_CYCLES(TICK_CYCLES)) i_cam_monitor_properties (
	.clk(clk), .reset_n(reset_n), .apb_req(apb_req), .apb_rsp(apb_rsp), .drive(drive),
	.pins(pins));
`default_nettype wire
